// >>> common/tsitia_pkg.sv
// Constants and types for the ranging sensor two-wire target port
package tsitia_pkg;
    // ------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR7 = 7'h29;
    localparam logic [7:0] ADDR_WRITE = 8'h52;
    localparam logic [7:0] ADDR_READ = 8'h53;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    localparam logic [15:0] INDEX_STEP = 16'h0001;
    // ------------------------------------------------------------
    // Byte framing
    // ------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int BUS_MAX_BPS = 1000000;
    // Shortest serial clock high time in ns, and the clock cycles it spans
    localparam int SCL_HIGH_MIN_NS = 260;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    localparam int SCL_HIGH_MIN_CYC = SCL_HIGH_MIN_NS / CLK_PERIOD_NS;
    localparam int CYC_PER_BIT = CLK_HZ / BUS_MAX_BPS;
    // ------------------------------------------------------------
    // Port states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_IDX_HI,
        S_IDX_LO,
        S_WDATA,
        S_ACK,
        S_RDATA,
        S_HACK,
        S_RLOAD,
        S_IGNORE
    } tsitia_state_type;
endpackage : tsitia_pkg

// >>> verilog/tsitia_target.sv
// Two-wire target port with 16-bit register index and auto-increment
`timescale 1ns/100ps
// Summary of operation
// - Acknowledge address byte 0x52; low direction bit means master writes.
// - Address byte 0x53 means master reads from the sensor.
// - Master alone drives the clock and starts transfers, at most 1 Mbit/s.
// - Each transfer unit is one byte followed by one acknowledge slot.
// - Receiver samples on rising clock; transmitter holds data while clock high.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Repeated start ends a message and begins another, accepted like stop.
// - Acknowledge own address by pulling data low; latch the direction bit.
// - Shift in each byte, acknowledge it, store it at the current index.
// - In reads load the indexed register, shift it out on falling edges.
// - Receiver acknowledges each byte: sensor on writes, host on reads.
// - Index increments by one after each data byte.
// - Lines are only pulled low, otherwise released to pull-ups.
// - No response in low-power idle while the comms enable is in use.
// - In low-power mode ignore traffic while comms enable is 0, accept at 1.
// - Interface reset pin pulse resets only the serial port logic.
module tsitia_target (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Serial pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Control pins and power state
    input wire logic i_port_reset_pin,
    input wire logic i_lowpower_comms_enable,
    input wire logic i_low_power_idle_state,
    // Sensor register side
    output logic [15:0] o_index,
    output logic o_wr_strobe,
    output logic [15:0] o_wr_index,
    output logic [7:0] o_wr_data,
    output logic o_rd_strobe,
    input wire logic [7:0] i_rd_data
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [tsitia_pkg::SYNC_STAGES-1:0] scl_sync;
    logic [tsitia_pkg::SYNC_STAGES-1:0] sda_sync;
    logic [tsitia_pkg::SYNC_STAGES-1:0] rstpin_sync;
    logic [tsitia_pkg::SYNC_STAGES-1:0] lpce_sync;
    logic scl_q;
    logic sda_q;
    logic scl_s;
    logic sda_s;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            scl_sync <= '1;
            sda_sync <= '1;
            rstpin_sync <= '0;
            lpce_sync <= '1;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            rstpin_sync <= {rstpin_sync[0], i_port_reset_pin};
            lpce_sync <= {lpce_sync[0], i_lowpower_comms_enable};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    logic port_rst;
    logic blocked;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Pin held high keeps only this port in reset; the sensor core is untouched
    assign port_rst = i_reset | rstpin_sync[1];
    assign blocked = i_low_power_idle_state & ~lpce_sync[1];
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

    // ------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------
    tsitia_pkg::tsitia_state_type state;
    tsitia_pkg::tsitia_state_type ret;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic oe;
    logic dir;
    logic [15:0] index;
    logic wr_strobe;
    logic [15:0] wr_index;
    logic [7:0] wr_data;
    logic rd_strobe;

    tsitia_pkg::tsitia_state_type next_state;
    tsitia_pkg::tsitia_state_type next_ret;
    logic [2:0] next_cnt;
    logic [7:0] next_shift;
    logic next_oe;
    logic next_dir;
    logic [15:0] next_index;
    logic next_wr_strobe;
    logic [15:0] next_wr_index;
    logic [7:0] next_wr_data;
    logic next_rd_strobe;
    logic [7:0] byte_in;

    assign byte_in = {shift[6:0], sda_s};

    always_comb begin
        logic do_load;
        do_load = 1'h0;
        next_state = state;
        next_ret = ret;
        next_cnt = cnt;
        next_shift = shift;
        next_oe = oe;
        next_dir = dir;
        next_index = index;
        next_wr_strobe = 1'h0;
        next_wr_index = wr_index;
        next_wr_data = wr_data;
        next_rd_strobe = 1'h0;
        if (blocked) begin
            next_state = tsitia_pkg::S_IDLE;
            next_oe = 1'h0;
        end else if (start_det) begin
            next_state = tsitia_pkg::S_ADDR;
            next_cnt = tsitia_pkg::BIT_FIRST;
            next_oe = 1'h0;
        end else if (stop_det) begin
            next_state = tsitia_pkg::S_IDLE;
            next_oe = 1'h0;
        end else begin
            case (state)
                tsitia_pkg::S_ADDR,
                tsitia_pkg::S_IDX_HI,
                tsitia_pkg::S_IDX_LO,
                tsitia_pkg::S_WDATA: begin
                    if (scl_rise) begin
                        next_shift = byte_in;
                        next_cnt = cnt + tsitia_pkg::BIT_STEP;
                        if (cnt == tsitia_pkg::BIT_LAST) begin
                            next_state = tsitia_pkg::S_ACK;
                            if (state == tsitia_pkg::S_ADDR) begin
                                if (byte_in[7:1] == tsitia_pkg::DEV_ADDR7) begin
                                    next_dir = byte_in[0];
                                    next_ret = byte_in[0] ? tsitia_pkg::S_RLOAD
                                                          : tsitia_pkg::S_IDX_HI;
                                end else begin
                                    next_state = tsitia_pkg::S_IGNORE;
                                end
                            end else if (state == tsitia_pkg::S_IDX_HI) begin
                                next_index[15:8] = byte_in;
                                next_ret = tsitia_pkg::S_IDX_LO;
                            end else if (state == tsitia_pkg::S_IDX_LO) begin
                                next_index[7:0] = byte_in;
                                next_ret = tsitia_pkg::S_WDATA;
                            end else begin
                                next_wr_strobe = 1'h1;
                                next_wr_data = byte_in;
                                next_wr_index = index;
                                next_index = index + tsitia_pkg::INDEX_STEP;
                                next_ret = tsitia_pkg::S_WDATA;
                            end
                        end
                    end
                end
                tsitia_pkg::S_ACK: begin
                    if (scl_fall) begin
                        if (!oe) begin
                            next_oe = 1'h1;
                        end else begin
                            next_oe = 1'h0;
                            next_cnt = tsitia_pkg::BIT_FIRST;
                            if (ret == tsitia_pkg::S_RLOAD) begin
                                do_load = 1'h1;
                            end else begin
                                next_state = ret;
                            end
                        end
                    end
                end
                tsitia_pkg::S_RDATA: begin
                    if (scl_fall) begin
                        next_shift = {shift[6:0], 1'h0};
                        next_oe = ~shift[6];
                    end
                    if (scl_rise) begin
                        next_cnt = cnt + tsitia_pkg::BIT_STEP;
                        if (cnt == tsitia_pkg::BIT_LAST) begin
                            next_state = tsitia_pkg::S_HACK;
                        end
                    end
                end
                tsitia_pkg::S_HACK: begin
                    // Release so the host can drive its acknowledge
                    if (scl_fall) begin
                        next_oe = 1'h0;
                    end
                    if (scl_rise) begin
                        next_index = index + tsitia_pkg::INDEX_STEP;
                        next_state = sda_s ? tsitia_pkg::S_IGNORE
                                           : tsitia_pkg::S_RLOAD;
                    end
                end
                tsitia_pkg::S_RLOAD: begin
                    if (scl_fall) begin
                        do_load = 1'h1;
                    end
                end
                tsitia_pkg::S_IDLE,
                tsitia_pkg::S_IGNORE: begin
                    next_oe = 1'h0;
                end
                default: begin
                    next_state = tsitia_pkg::S_IDLE;
                    next_oe = 1'h0;
                end
            endcase
            if (do_load) begin
                next_shift = i_rd_data;
                next_oe = ~i_rd_data[7];
                next_rd_strobe = 1'h1;
                next_cnt = tsitia_pkg::BIT_FIRST;
                next_state = tsitia_pkg::S_RDATA;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (port_rst) begin
            state <= tsitia_pkg::S_IDLE;
            ret <= tsitia_pkg::S_IDLE;
            cnt <= tsitia_pkg::BIT_FIRST;
            shift <= tsitia_pkg::BYTE_RESET;
            oe <= 1'h0;
            dir <= tsitia_pkg::DIR_WRITE;
            index <= tsitia_pkg::INDEX_RESET;
            wr_strobe <= 1'h0;
            wr_index <= tsitia_pkg::INDEX_RESET;
            wr_data <= tsitia_pkg::BYTE_RESET;
            rd_strobe <= 1'h0;
        end else begin
            state <= next_state;
            ret <= next_ret;
            cnt <= next_cnt;
            shift <= next_shift;
            oe <= next_oe;
            dir <= next_dir;
            index <= next_index;
            wr_strobe <= next_wr_strobe;
            wr_index <= next_wr_index;
            wr_data <= next_wr_data;
            rd_strobe <= next_rd_strobe;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain: the pad only ever sees a low drive value
    assign o_sda_out = 1'h0;
    assign o_sda_oe = oe;
    assign o_index = index;
    assign o_wr_strobe = wr_strobe;
    assign o_wr_index = wr_index;
    assign o_wr_data = wr_data;
    assign o_rd_strobe = rd_strobe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_drive_on_fall: assert property (@(posedge i_clk) disable iff (port_rst)
        $rose(oe) |-> $past(scl_fall))
        else $error("Data drive began away from a clock fall");

    a_quiet_blocked: assert property (@(posedge i_clk) disable iff (port_rst)
        blocked |=> !oe && state == tsitia_pkg::S_IDLE)
        else $error("Port answered while comms were disabled");

    a_start_addr: assert property (@(posedge i_clk) disable iff (port_rst)
        start_det && !blocked |=> state == tsitia_pkg::S_ADDR && cnt == tsitia_pkg::BIT_FIRST)
        else $error("Start did not open address phase");

    a_stop_idle: assert property (@(posedge i_clk) disable iff (port_rst)
        stop_det && !blocked |=> state == tsitia_pkg::S_IDLE && !oe)
        else $error("Stop did not return port to idle");

    a_addr_write: assert property (@(posedge i_clk) disable iff (port_rst)
        state == tsitia_pkg::S_ADDR && scl_rise && cnt == tsitia_pkg::BIT_LAST
        && byte_in == tsitia_pkg::ADDR_WRITE && !blocked && !start_det && !stop_det
        |=> state == tsitia_pkg::S_ACK && dir == tsitia_pkg::DIR_WRITE
        && ret == tsitia_pkg::S_IDX_HI)
        else $error("Write address not accepted");

    a_addr_read: assert property (@(posedge i_clk) disable iff (port_rst)
        state == tsitia_pkg::S_ADDR && scl_rise && cnt == tsitia_pkg::BIT_LAST
        && byte_in == tsitia_pkg::ADDR_READ && !blocked && !start_det && !stop_det
        |=> dir == tsitia_pkg::DIR_READ && ret == tsitia_pkg::S_RLOAD)
        else $error("Read address not accepted");

    a_foreign_addr: assert property (@(posedge i_clk) disable iff (port_rst)
        state == tsitia_pkg::S_ADDR && scl_rise && cnt == tsitia_pkg::BIT_LAST
        && byte_in[7:1] != tsitia_pkg::DEV_ADDR7 && !blocked && !start_det && !stop_det
        |=> state == tsitia_pkg::S_IGNORE && !oe)
        else $error("Foreign address was not ignored");

    a_write_step: assert property (@(posedge i_clk) disable iff (port_rst)
        wr_strobe |-> index == wr_index + tsitia_pkg::INDEX_STEP
        && wr_data == $past(byte_in))
        else $error("Written byte or index step wrong");

    a_read_load: assert property (@(posedge i_clk) disable iff (port_rst)
        rd_strobe |-> state == tsitia_pkg::S_RDATA && shift == $past(i_rd_data)
        && oe == ~shift[7])
        else $error("Read byte not loaded onto the line");

    a_index_high: assert property (@(posedge i_clk) disable iff (port_rst)
        state == tsitia_pkg::S_IDX_HI && scl_rise && cnt == tsitia_pkg::BIT_LAST
        && !blocked && !start_det && !stop_det
        |=> index[15:8] == $past(byte_in) && ret == tsitia_pkg::S_IDX_LO)
        else $error("Index high byte not captured first");

    a_pin_reset: assert property (@(posedge i_clk)
        rstpin_sync[1] |=> state == tsitia_pkg::S_IDLE && !oe
        && index == tsitia_pkg::INDEX_RESET)
        else $error("Reset pin did not clear port");
endmodule : tsitia_target

// >>> tb/tsitia_host.sv
// Host bus master model that drives the two-wire link
`timescale 1ns/100ps
module tsitia_host (
    // Clock
    input wire logic i_clk,
    // Serial link
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    // 25 clocks a bit keeps the link at the 1 Mbit/s ceiling
    localparam int QTR = 6;
    initial begin
        o_scl = 1'h1;
        o_sda_oe = 1'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask : hold
    // Data moves only while the clock is low; sampled mid-high
    task automatic put_bit(input logic b, output logic seen);
        o_sda_oe <= ~b;
        hold(QTR);
        o_scl <= 1'h1;
        hold(QTR);
        seen = i_sda;
        hold(QTR);
        o_scl <= 1'h0;
        hold(QTR + 1);
    endtask : put_bit
    task automatic bus_start();
        o_sda_oe <= 1'h0;
        hold(QTR);
        o_scl <= 1'h1;
        hold(2 * QTR);
        o_sda_oe <= 1'h1;
        hold(2 * QTR);
        o_scl <= 1'h0;
        hold(QTR + 1);
    endtask : bus_start
    task automatic bus_stop();
        o_sda_oe <= 1'h1;
        hold(QTR);
        o_scl <= 1'h1;
        hold(2 * QTR);
        o_sda_oe <= 1'h0;
        hold(2 * QTR);
    endtask : bus_stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'h1, s);
        ack = ~s;
    endtask : send_byte
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'h1, s);
            b[i] = s;
        end
        put_bit(~give_ack, s);
    endtask : recv_byte
endmodule : tsitia_host

// >>> tb/tof_sensor_i2c_target_index_access_bench.sv
// Self-checking bench for the two-wire target port
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %0t got %h expected %h", $time, got, exp); end end
module tof_sensor_i2c_target_index_access_bench;
    logic clk;
    logic reset;
    logic scl;
    logic host_oe;
    logic sda_out;
    logic sda_oe;
    wire logic sda;
    logic port_reset_pin;
    logic comms_enable;
    logic low_power_idle_state;
    logic [15:0] index;
    logic wr_strobe;
    logic [15:0] wr_index;
    logic [7:0] wr_data;
    logic rd_strobe;
    logic [7:0] rd_data;
    logic [7:0] regs [0:255];
    logic [23:0] wq [$];
    int rd_count = 0;
    int drive_high = 0;
    int err_count;
    int comparisons;
    localparam logic [7:0] WD [3] = '{8'h3C, 8'hC3, 8'h5A};
    // Open-drain wire with pull-up
    assign sda = !(host_oe || (sda_oe && !sda_out));
    assign rd_data = regs[index[7:0]];
    tsitia_target DUT (.i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_port_reset_pin(port_reset_pin),
        .i_lowpower_comms_enable(comms_enable), .i_low_power_idle_state(low_power_idle_state),
        .o_index(index), .o_wr_strobe(wr_strobe), .o_wr_index(wr_index),
        .o_wr_data(wr_data), .o_rd_strobe(rd_strobe), .i_rd_data(rd_data));
    tsitia_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Register-side model and monitors
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (wr_strobe === 1'h1) begin
            wq.push_back({wr_index, wr_data});
            regs[wr_index[7:0]] <= wr_data;
        end
        if (rd_strobe === 1'h1) rd_count++;
        if (sda_oe === 1'h1 && sda_out !== 1'h0) drive_high++;
    end
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic set_index(input logic [7:0] hi, input logic [7:0] lo);
        logic a;
        host.bus_start();
        host.send_byte(8'h52, a);
        `CHK(a, 1'h1)
        host.send_byte(hi, a);
        `CHK(a, 1'h1)
        host.send_byte(lo, a);
        `CHK(a, 1'h1)
    endtask : set_index
    // Burst crossing a low-byte boundary of the index
    task automatic t_write();
        logic a;
        wq.delete();
        set_index(8'h12, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            host.send_byte(WD[i], a);
            `CHK(a, 1'h1)
        end
        host.bus_stop();
        `CHK(wq.size(), 3)
        for (int i = 0; i < 3; i++) begin
            `CHK(wq[i], {16'h12FF + 16'(i), WD[i]})
        end
        `CHK(index, 16'h1302)
        `CHK(sda_oe, 1'h0)
    endtask : t_write
    task automatic t_read();
        logic a;
        logic [7:0] d;
        int rd_base;
        set_index(8'h12, 8'hFF);
        // First load lands inside the address acknowledge, so count from here
        rd_base = rd_count;
        host.bus_start();
        host.send_byte(8'h53, a);
        `CHK(a, 1'h1)
        for (int i = 0; i < 3; i++) begin
            host.recv_byte(i < 2, d);
            `CHK(d, WD[i])
        end
        host.bus_stop();
        `CHK(rd_count - rd_base, 3)
        `CHK(index, 16'h1302)
    endtask : t_read
    task automatic t_foreign();
        logic a;
        wq.delete();
        host.bus_start();
        host.send_byte(8'h54, a);
        `CHK(a, 1'h0)
        host.send_byte(8'h52, a);
        `CHK(a, 1'h0)
        host.bus_stop();
        `CHK(wq.size(), 0)
    endtask : t_foreign
    // Power state and comms enable combinations
    task automatic t_blocked();
        logic a;
        // Only low-power idle with the enable at 0 may silence the port
        for (int k = 0; k < 4; k++) begin
            low_power_idle_state <= ~k[1];
            comms_enable <= k[0];
            host.hold(4);
            host.bus_start();
            host.send_byte(8'h52, a);
            `CHK(a, (k != 0))
            host.bus_stop();
        end
        low_power_idle_state <= 1'h0;
        comms_enable <= 1'h1;
    endtask : t_blocked
    task automatic t_port_reset();
        logic a;
        host.bus_start();
        host.send_byte(8'h52, a);
        port_reset_pin <= 1'h1;
        host.hold(4);
        port_reset_pin <= 1'h0;
        host.hold(6);
        `CHK(sda_oe, 1'h0)
        `CHK(index, tsitia_pkg::INDEX_RESET)
        host.send_byte(8'h52, a);
        `CHK(a, 1'h0)
        host.bus_stop();
        wq.delete();
        set_index(8'h00, 8'h10);
        host.send_byte(8'h77, a);
        host.bus_stop();
        `CHK(wq[0], 24'h001077)
    endtask : t_port_reset
    initial begin
        reset = 1'h1;
        port_reset_pin = 1'h0;
        comms_enable = 1'h1;
        low_power_idle_state = 1'h0;
        err_count = 0;
        comparisons = 0;
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'hA5;
        end
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        host.hold(4);
        t_write();
        t_read();
        t_foreign();
        t_blocked();
        t_port_reset();
        `CHK(drive_high, 0)
        report_and_stop();
    end
    // Whole run needs about 6300 clocks
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule : tof_sensor_i2c_target_index_access_bench
